// [pcpc_cfg.svh]
// Constants for the port charge and power control block
`ifndef PCPC_CFG_SVH
`define PCPC_CFG_SVH
`define PCPC_ADDR_PWR 8'h05
`define PCPC_ADDR_CHG 8'h06
`define PCPC_ADDR_POL 8'h0A
`define PCPC_PWR_DIS_N_BIT 0
`define PCPC_PWR_GANGED_BIT 3
`define PCPC_POL_AUTO_DIS_N_BIT 1
`define PCPC_POL_PWRPOL_BIT 2
`define PCPC_POL_GALT_BIT 5
`define PCPC_POL_HICUR_BIT 4
`define PCPC_RST_PWR 8'h00
`define PCPC_RST_CHG 8'h00
`define PCPC_RST_POL 8'h00
`define PCPC_OFF_NS 1000
`define PCPC_OFF_CYC ((`PCPC_OFF_NS + 7) / 8)
`endif

// [pcpc_pkg.sv]
// Types for the port charge and power control block
package pcpc_pkg;
  typedef enum logic [2:0] {
    PCPC_NONE, PCPC_CDP, PCPC_DCP, PCPC_DIV_LO, PCPC_DIV_HI, PCPC_ALT
  } pcpc_mode_t;
endpackage

// [pcpc_top.sv]
// Port charge mode and power switch control for four downstream ports
`timescale 1ns/100ps
`default_nettype none
`include "pcpc_cfg.svh"

module pcpc_top (
  input wire logic sys_clk_i,            // Core clock
  input wire logic sys_rst_i,            // Async reset, high
  input wire logic [7:0] cfg_addr_i,     // Config register address
  input wire logic cfg_wr_i,             // Config write strobe
  input wire logic [7:0] cfg_wdata_i,    // Config write data
  output logic [7:0] cfg_rdata_o,        // Config read data
  input wire logic use_regs_i,           // 1: bus/EEPROM config
  input wire logic [3:0] charge_enable_straps_i,
  input wire logic auto_mode_strap_n_i,
  input wire logic power_mgmt_strap_n_i,
  input wire logic ganged_strap_i,
  input wire logic bus_mode_strap_n_i,
  input wire logic power_polarity_strap_i,
  input wire logic vbus_valid_i,         // Upstream VBUS above 4V
  input wire logic us_connected_i,       // Upstream port connected
  input wire logic us_configured_i,      // Upstream port configured
  input wire logic [3:0] host_port_power_i, // Host set port power
  input wire logic [3:0] dp_pullup_i,    // DP pull-up seen per port
  input wire logic [3:0] data_line_voltage_detect_i,
  input wire logic [3:0] ovc_n_i,        // Over-current inputs, low
  output logic [3:0] port_power_enable_out_o,
  output logic [3:0] ovc_o,              // Over-current per port
  output logic [3:0] divider_drive_o,    // Fixed DP/DM level on
  output logic [3:0] divider_high_o,     // High divider level
  output logic [11:0] port_mode_o,       // 3-bit mode per port
  output logic bus_mode_n_o              // Sampled bus mode strap
);
  import pcpc_pkg::*;

  localparam int unsigned OFF_CYC = `PCPC_OFF_CYC;

  logic [7:0] pwr_q, chg_q, pol_q;        // Config registers
  logic strap_done_q;                     // Straps captured
  logic [3:0] st_chg_q;                   // Sampled straps
  logic st_auto_n_q, st_pm_n_q, st_gang_q, st_bus_n_q, st_pol_q;
  pcpc_mode_t mode_q [4];                 // Automatic mode state
  logic [3:0] pwr_on_q;                   // Internal power enable
  logic [3:0] seq_q;                      // Auto sequence started
  logic [7:0] off_cnt_q [4];              // Power-off hold counters

  // Effective configuration selection
  wire [3:0] chg_en = use_regs_i ? chg_q[3:0] : st_chg_q;
  // Register bit set means automatic mode is off
  wire auto_en = use_regs_i ? ~pol_q[`PCPC_POL_AUTO_DIS_N_BIT]
                            : ~st_auto_n_q;
  wire auto_on = ~auto_en ? 1'b0 : 1'b1;
  wire hi_en = use_regs_i ? pol_q[`PCPC_POL_HICUR_BIT] : 1'b1;
  wire alt_en = use_regs_i & pol_q[`PCPC_POL_GALT_BIT];
  wire pol_hi = use_regs_i ? pol_q[`PCPC_POL_PWRPOL_BIT] : st_pol_q;
  wire sw_dis_n = use_regs_i ? pwr_q[`PCPC_PWR_DIS_N_BIT] : st_pm_n_q;
  wire gang_cfg = use_regs_i ? pwr_q[`PCPC_PWR_GANGED_BIT] : st_gang_q;
  wire ganged = gang_cfg & ~(|chg_en);
  wire sw_on = ~sw_dis_n;
  wire unconn = ~us_connected_i;
  wire wr_pwr = cfg_wr_i && cfg_addr_i == `PCPC_ADDR_PWR;
  wire wr_chg = cfg_wr_i && cfg_addr_i == `PCPC_ADDR_CHG;
  wire wr_pol = cfg_wr_i && cfg_addr_i == `PCPC_ADDR_POL;
  wire sel_pwr = cfg_addr_i == `PCPC_ADDR_PWR;
  wire sel_chg = cfg_addr_i == `PCPC_ADDR_CHG;
  wire sel_pol = cfg_addr_i == `PCPC_ADDR_POL;
  wire start_hi = hi_en;

  // Read mux, unmapped reads as zero
  always_comb begin
    if (sel_pwr) begin
      cfg_rdata_o = pwr_q;
    end else if (sel_chg) begin
      cfg_rdata_o = chg_q;
    end else if (sel_pol) begin
      cfg_rdata_o = pol_q;
    end else begin
      cfg_rdata_o = 8'h00;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwr_q <= `PCPC_RST_PWR;
      chg_q <= `PCPC_RST_CHG;
      pol_q <= `PCPC_RST_POL;
    end else begin
      if (wr_pwr) pwr_q <= cfg_wdata_i;
      if (wr_chg) chg_q <= cfg_wdata_i;
      if (wr_pol) pol_q <= cfg_wdata_i;
    end
  end

  // Strap capture on first edge after reset release
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_done_q <= 1'b0;
      st_chg_q <= 4'h0;
      st_auto_n_q <= 1'b1;
      st_pm_n_q <= 1'b1;
      st_gang_q <= 1'b0;
      st_bus_n_q <= 1'b1;
      st_pol_q <= 1'b1;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      st_chg_q <= charge_enable_straps_i;
      st_auto_n_q <= auto_mode_strap_n_i;
      st_pm_n_q <= power_mgmt_strap_n_i;
      st_gang_q <= ganged_strap_i;
      st_bus_n_q <= bus_mode_strap_n_i;
      st_pol_q <= power_polarity_strap_i;
    end
  end

  assign bus_mode_n_o = st_bus_n_q;

  // Per-port mode sequencer
  for (genvar p = 0; p < 4; p++) begin : g_port
    wire cdp_ok = vbus_valid_i & us_configured_i & host_port_power_i[p];
    wire div_mode = mode_q[p] == PCPC_DIV_LO || mode_q[p] == PCPC_DIV_HI;
    wire holding = off_cnt_q[p] != 8'h00;
    pcpc_mode_t div_start;
    assign div_start = start_hi ? PCPC_DIV_HI : PCPC_DIV_LO;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        mode_q[p] <= PCPC_NONE;
        pwr_on_q[p] <= 1'b0;
        off_cnt_q[p] <= 8'h00;
        seq_q[p] <= 1'b0;
      end else if (!chg_en[p]) begin
        mode_q[p] <= PCPC_NONE;
        pwr_on_q[p] <= host_port_power_i[p];
        off_cnt_q[p] <= 8'h00;
        seq_q[p] <= 1'b0;
      end else if (!unconn) begin
        mode_q[p] <= cdp_ok ? PCPC_CDP : PCPC_NONE;
        pwr_on_q[p] <= host_port_power_i[p];
        off_cnt_q[p] <= 8'h00;
        seq_q[p] <= 1'b0;
      end else if (!auto_on) begin
        mode_q[p] <= PCPC_DCP;
        pwr_on_q[p] <= 1'b1;
        off_cnt_q[p] <= 8'h00;
        seq_q[p] <= 1'b0;
      end else if (!seq_q[p]) begin
        // Entering auto always starts at the divider level
        mode_q[p] <= div_start;
        pwr_on_q[p] <= 1'b1;
        off_cnt_q[p] <= 8'h00;
        seq_q[p] <= 1'b1;
      end else if (holding) begin
        off_cnt_q[p] <= off_cnt_q[p] - 8'h01;
        pwr_on_q[p] <= (off_cnt_q[p] == 8'h01);
      end else begin
        pwr_on_q[p] <= 1'b1;
        case (mode_q[p])
          PCPC_DIV_LO, PCPC_DIV_HI: begin
            if (dp_pullup_i[p]) begin
              mode_q[p] <= alt_en ? PCPC_ALT : PCPC_DCP;
              pwr_on_q[p] <= 1'b0;
              off_cnt_q[p] <= OFF_CYC[7:0];
            end
          end
          PCPC_ALT: begin
            if (dp_pullup_i[p]) begin
              mode_q[p] <= PCPC_DCP;
              pwr_on_q[p] <= 1'b0;
              off_cnt_q[p] <= OFF_CYC[7:0];
            end
          end
          PCPC_DCP: begin
            if (dp_pullup_i[p] | data_line_voltage_detect_i[p]) begin
              mode_q[p] <= div_start;
              pwr_on_q[p] <= 1'b0;
              off_cnt_q[p] <= OFF_CYC[7:0];
            end
          end
          default: begin
            mode_q[p] <= div_start;
          end
        endcase
      end
    end

    // Divider level drive on DP/DM
    assign divider_drive_o[p] = div_mode;
    assign divider_high_o[p] = mode_q[p] == PCPC_DIV_HI;
    assign port_mode_o[3*p +: 3] = mode_q[p];
    // Polarity and switch enable on the power-enable outputs
    wire en = sw_on & (ganged ? (|pwr_on_q) : pwr_on_q[p]);
    assign port_power_enable_out_o[p] = pol_hi ? en : ~en;
    // Over-current, shared when ganged
    assign ovc_o[p] = ganged ? ~(&ovc_n_i) : ~ovc_n_i[p];
  end
endmodule
`default_nettype wire

// [pcpc_asserts.sv]
// Checker for the port charge and power control block
`timescale 1ns/100ps
`default_nettype none
module pcpc_asserts (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic use_regs_i,
  input wire logic us_connected_i,
  input wire logic [3:0] dp_pullup_i,
  input wire logic [3:0] ovc_n_i,
  input wire logic [3:0] port_power_enable_out_o,
  input wire logic [3:0] ovc_o,
  input wire logic [3:0] divider_drive_o,
  input wire logic [11:0] port_mode_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [3:0] chg_q; // Shadow charge enables
  logic [7:0] cm_q; // Shadow mode and polarity register
  wire [2:0] m0 = port_mode_o[2:0]; // Port 0 mode
  wire on0 = port_power_enable_out_o[0] == cm_q[2]; // Port 0 powered
  wire dv0 = m0 == 3'h3 || m0 == 3'h4; // Port 0 in a divider mode
  wire au = use_regs_i && !us_connected_i; // Register mode, unconnected
  // Follow register writes
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      chg_q <= 4'h0;
      cm_q <= 8'h00;
    end else if (cfg_wr_i) begin
      if (cfg_addr_i == 8'h06) chg_q <= cfg_wdata_i[3:0];
      if (cfg_addr_i == 8'h0A) cm_q <= cfg_wdata_i;
    end
  end
  AST_NO_CHG: assert property ((use_regs_i && !chg_q[0]) [*3]
    |-> m0 == 3'h0) else $error("mode on disabled port");
  AST_AUTO_OFF: assert property ((au && cm_q[1] && chg_q[0]) [*3]
    |-> m0 == 3'h2) else $error("not DCP with auto off");
  AST_NO_DIV_CONN: assert property (us_connected_i [*3]
    |-> m0 < 3'h3 && !divider_drive_o[0]) else $error("divider connected");
  AST_DIV_DRIVE: assert property (divider_drive_o[0] == dv0)
    else $error("divider drive mismatch");
  AST_PULLUP_OFF: assert property (au && dv0 && on0 && dp_pullup_i[0]
    |=> (m0 == 3'h2 || m0 == 3'h5) && !on0) else $error("bad divider exit");
  AST_HOLD_OFF: assert property (au && $fell(on0) |=> !on0 [*8])
    else $error("power off too short");
  AST_DCP_BACK: assert property (au && !cm_q[1] && m0 == 3'h2 && on0
    && dp_pullup_i[0] |=> dv0 && !on0) else $error("bad DCP exit");
  AST_OVC: assert property ((use_regs_i && chg_q[0]) [*2]
    |-> ovc_o[0] == !ovc_n_i[0]) else $error("over-current mismatch");
  cover property (m0 == 3'h5);
  cover property (m0 == 3'h1);
  cover property (dv0 && on0 && dp_pullup_i[0]);
endmodule
bind pcpc_top pcpc_asserts u_chk (.*);
`default_nettype wire

// [pcpc_partner.sv]
// Model of the downstream power switches and attached devices
`timescale 1ns/100ps
`default_nettype none
module pcpc_partner (
  input wire logic clk_i,
  input wire logic pol_i, // Active level of the enables
  input wire logic [3:0] pwr_en_i, // Power enables from the hub
  input wire logic [3:0] attach_i, // Device plugged into the port
  input wire logic [3:0] fault_i, // Load draws too much current
  output logic [3:0] dp_pullup_o, // Device pull-up on DP
  output logic [3:0] ovc_n_o // Over-current flag, low
);
  wire [3:0] pwr = pwr_en_i ^ {4{!pol_i}}; // Switch closed
  // A device pulls DP up only once its supply is present
  always_ff @(posedge clk_i) dp_pullup_o <= pwr & attach_i;
  // Only a powered switch can trip
  assign ovc_n_o = ~(pwr & fault_i);
endmodule
`default_nettype wire

// [pcpc_top_tb_top.sv]
// Self-checking bench for the port charge and power control block
`timescale 1ns/100ps
`default_nettype none
`include "pcpc_cfg.svh"
module pcpc_top_tb_top;
  import pcpc_pkg::*;
  logic sys_clk_i, sys_rst_i, cfg_wr_i, use_regs_i, vbus_valid_i, pol;
  logic us_connected_i, us_configured_i, bus_mode_n_o, ganged_strap_i;
  logic auto_mode_strap_n_i, power_mgmt_strap_n_i;
  logic bus_mode_strap_n_i, power_polarity_strap_i;
  logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o;
  logic [3:0] charge_enable_straps_i, host_port_power_i, dp_pullup_i;
  logic [3:0] data_line_voltage_detect_i, ovc_n_i, port_power_enable_out_o;
  logic [3:0] ovc_o, divider_drive_o, divider_high_o, attach, fault;
  logic [11:0] port_mode_o;
  int mismatches, total_checks;
  pcpc_top DUT (.*);
  pcpc_partner u_far (.clk_i(sys_clk_i), .pol_i(pol), .attach_i(attach),
    .pwr_en_i(port_power_enable_out_o), .fault_i(fault),
    .dp_pullup_o(dp_pullup_i), .ovc_n_o(ovc_n_i));
  function automatic void chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endfunction
  function automatic logic [2:0] md(input int p);
    return port_mode_o[3*p +: 3];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    {cfg_addr_i, cfg_wdata_i, cfg_wr_i} = {a, d, 1'b1};
    @(negedge sys_clk_i);
    cfg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_i);
    cfg_addr_i = a;
    #1 chk(cfg_rdata_o, e);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Reset values, unmapped place, enable field
  task automatic t_regs();
    rd(8'h05, 8'h00);
    rd(8'h0A, 8'h00);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    wr(8'h06, 8'h0E);
    rd(8'h06, 8'h0E);
    chk(bus_mode_n_o, 1'b1);
    $display("test regs done");
  endtask
  // Auto off: DCP on enabled ports, then polarity flip
  task automatic t_dcp();
    wr(8'h0A, 8'h06);
    cyc(200);
    chk(md(0), PCPC_NONE);
    chk(md(1), PCPC_DCP);
    chk(port_power_enable_out_o, 4'hE);
    pol = 1'b0;
    wr(8'h0A, 8'h02);
    chk(port_power_enable_out_o, 4'h1);
    $display("test dcp done");
  endtask
  // Auto on: divider, alternate, DCP, divider again
  task automatic t_auto();
    logic [2:0] last;
    logic [2:0] seq [$];
    int run;
    int minrun;
    {pol, last, run, minrun} = {1'b1, PCPC_DIV_HI, 32'd0, 32'd9999};
    wr(8'h06, 8'h0F);
    wr(8'h0A, 8'h34);
    cyc(3);
    chk(md(0), PCPC_DIV_HI);
    chk(divider_drive_o[0], 1'b1);
    chk(divider_high_o[0], 1'b1);
    attach = 4'h1;
    repeat (800) begin
      @(negedge sys_clk_i);
      if (md(0) !== last) seq.push_back(md(0));
      last = md(0);
      if (port_power_enable_out_o[0] === 1'b0) run++;
      else if (run > 0) {minrun, run} = {(run < minrun) ? run : minrun, 32'd0};
    end
    chk({seq[0], seq[1], seq[2], seq[3]},
      {PCPC_ALT, PCPC_DCP, PCPC_DIV_HI, PCPC_ALT});
    chk(minrun >= `PCPC_OFF_CYC, 1'b1);
    attach = 4'h0;
    $display("test auto done");
  endtask
  // Connected host: CDP only where host powers the port
  task automatic t_cdp();
    {us_connected_i, vbus_valid_i, us_configured_i} = 3'h7;
    host_port_power_i = 4'h1;
    cyc(130);
    chk(md(0), PCPC_CDP);
    chk(md(1), PCPC_NONE);
    chk(divider_drive_o, 4'h0);
    fault = 4'h1;
    cyc(1);
    chk(ovc_o, 4'h1);
    $display("test cdp done");
  endtask
  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    {cfg_wr_i, vbus_valid_i, us_connected_i, us_configured_i} = 4'h0;
    {cfg_addr_i, cfg_wdata_i, host_port_power_i, attach, fault} = 28'h0;
    {use_regs_i, auto_mode_strap_n_i, power_mgmt_strap_n_i} = 3'h7;
    {bus_mode_strap_n_i, ganged_strap_i, power_polarity_strap_i} = 3'h4;
    {charge_enable_straps_i, data_line_voltage_detect_i, pol} = 9'h001;
    cyc(10);
    sys_rst_i = 1'b0;
    cyc(2);
    t_regs();
    t_dcp();
    t_auto();
    t_cdp();
    give_verdict();
  end
endmodule
`default_nettype wire
